// ===== full_status_master.sv
// master end: APB-controlled full status query over the frame carrier
// assumes APB on the same clock; zero-wait slave
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module full_status_master
  import full_status_pkg::*;
#(
  parameter int RESP_WAIT = 64 // cycles allowed before a response byte
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // interrupt
  output      logic        irq,
  // link
  lin_frame_if.master      link
);
  typedef enum logic [2:0] {H_IDLE, H_HDR, H_SEND, H_POLL, H_RECV} hstate_t;

  hstate_t     st_q;
  logic        long_q;
  logic        second_q;
  logic        pass_q;
  logic [6:0]  addr_q;
  logic [4:0]  did_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sum_q;
  logic [15:0] wait_q;
  logic [63:0] r1_q;
  logic [63:0] r2_q;
  logic [EV_W-1:0] ist_q;
  logic [EV_W-1:0] imask_q;
  logic [EV_W-1:0] ev;
  logic        hv_q;
  logic [7:0]  hid_q;
  logic        mv_q;
  logic [7:0]  md_q;
  logic [31:0] prdata_q;
  logic        wr;
  logic        start;
  logic [3:0]  len;
  logic [7:0]  body;
  logic        recv_end;
  logic        cks_ok;

  assign wr       = psel && penable && pwrite;
  assign start    = wr && (paddr == OFS_CTRL) && pwdata[CTRL_START] &&
                    (st_q == H_IDLE);
  assign len      = long_q ? LONG_LEN : SHORT_LEN;
  assign recv_end = (st_q == H_RECV) && link.s_valid && (cnt_q == RESP_LEN);
  assign cks_ok   = (link.s_data == ~sum_q);

  // preparing frame body byte for the current position
  always_comb begin
    body = FILL_BYTE;
    if (!long_q) begin
      body = (cnt_q == 4'h0) ? {TOP_ONE, CMD_FULL}
                             : {TOP_ONE, addr_q};
    end else if (cnt_q == 4'h0) begin
      body = APP_CMD;
    end else if (cnt_q == 4'h1) begin
      body = {TOP_ONE, CMD_FULL};
    end else if (cnt_q == 4'h2) begin
      body = {TOP_ONE, addr_q};
    end
  end

  // query sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= H_IDLE;
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
      pass_q <= 1'b0;
      wait_q <= 16'h0000;
      hv_q <= 1'b0;
      hid_q <= 8'h00;
      mv_q <= 1'b0;
      md_q <= 8'h00;
    end else begin
      hv_q <= 1'b0;
      mv_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (start) begin
            st_q <= H_HDR;
          end
        end
        H_HDR: begin
          hv_q <= 1'b1;
          hid_q <= long_q ? ID_DIAG : lin_pid({1'b0, did_q});
          cnt_q <= 4'h0;
          sum_q <= 8'h00;
          st_q <= H_SEND;
        end
        H_SEND: begin
          mv_q <= 1'b1;
          if (cnt_q == len) begin
            md_q <= ~sum_q;
            pass_q <= 1'b0;
            st_q <= H_POLL;
          end else begin
            md_q <= body;
            sum_q <= cks_add(sum_q, body);
            cnt_q <= cnt_q + 4'h1;
          end
        end
        H_POLL: begin
          hv_q <= 1'b1;
          hid_q <= ID_INDIRECT;
          cnt_q <= 4'h0;
          sum_q <= 8'h00;
          wait_q <= 16'h0000;
          st_q <= H_RECV;
        end
        H_RECV: begin
          if (link.s_valid) begin
            wait_q <= 16'h0000;
            sum_q <= cks_add(sum_q, link.s_data);
            cnt_q <= cnt_q + 4'h1;
            if (recv_end) begin
              pass_q <= 1'b1;
              // stop after the first answer unless positions wanted
              st_q <= (cks_ok && second_q && !pass_q) ? H_POLL
                                                       : H_IDLE;
            end
          end else if (wait_q == 16'(RESP_WAIT)) begin
            st_q <= H_IDLE;
          end else begin
            wait_q <= wait_q + 16'h0001;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // response capture, first byte in the top lane
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r1_q <= 64'h0;
      r2_q <= 64'h0;
    end else if (st_q == H_RECV && link.s_valid && cnt_q < RESP_LEN) begin
      if (pass_q) begin
        r2_q <= {r2_q[55:0], link.s_data};
      end else begin
        r1_q <= {r1_q[55:0], link.s_data};
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      long_q <= 1'b0;
      second_q <= 1'b0;
      addr_q <= 7'h00;
      did_q <= 5'h00;
      imask_q <= '0;
    end else if (wr) begin
      if (start) begin
        long_q <= pwdata[CTRL_LONG];
        second_q <= pwdata[CTRL_SECOND];
      end else if (paddr == OFS_TARGET) begin
        addr_q <= pwdata[6:0];
        did_q <= pwdata[12:8];
      end else if (paddr == OFS_INT_MASK) begin
        imask_q <= pwdata[EV_W-1:0];
      end
    end
  end

  // events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[EV_DONE] = recv_end && cks_ok && !(second_q && !pass_q);
    ev[EV_CKS_ERR] = recv_end && !cks_ok;
    ev[EV_NO_RESP] = (st_q == H_RECV) && !link.s_valid &&
                     (wait_q == 16'(RESP_WAIT));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ist_q <= '0;
    end else if (wr && paddr == OFS_INT_STAT) begin
      ist_q <= (ist_q & ~pwdata[EV_W-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  // read data sampled in the setup cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      if (paddr == OFS_CTRL) begin
        prdata_q <= {29'h0, second_q, long_q, 1'b0};
      end else if (paddr == OFS_TARGET) begin
        prdata_q <= {19'h0, did_q, 1'b0, addr_q};
      end else if (paddr == OFS_STATUS) begin
        prdata_q <= {31'h0, st_q != H_IDLE};
      end else if (paddr == OFS_INT_STAT) begin
        prdata_q <= {29'h0, ist_q};
      end else if (paddr == OFS_INT_MASK) begin
        prdata_q <= {29'h0, imask_q};
      end else if (paddr == OFS_R1_LO) begin
        prdata_q <= r1_q[31:0];
      end else if (paddr == OFS_R1_HI) begin
        prdata_q <= r1_q[63:32];
      end else if (paddr == OFS_R2_LO) begin
        prdata_q <= r2_q[31:0];
      end else if (paddr == OFS_R2_HI) begin
        prdata_q <= r2_q[63:32];
      end else begin
        prdata_q <= 32'h0; // unmapped reads zero
      end
    end
  end

  assign prdata         = prdata_q;
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign irq            = |(ist_q & imask_q);
  assign link.hdr_valid = hv_q;
  assign link.hdr_id    = hid_q;
  assign link.m_valid   = mv_q;
  assign link.m_data    = md_q;
endmodule

// ===== full_status_pkg.sv
// constants, encodings and helpers shared by both ends of the status link
// assumes one clock domain and byte-level frame transfer between the ends
// Summary of operation
// - one query returns the full device status
// - serving query pulses clear of latched fault flags
// - master opens query with short or long frame
// - two responses under indirect identifier follow
// - master may stop after first response
// - short form is followed by reading header
// - long form is followed by reading header
// - short frame: direct id, command, address
// - long frame: diagnostic id, app command, filler
// - first response: address, currents, velocities, motion
// - first response: fault, motion, link error bytes
// - second response: actual, target, secure positions
// - short frame identifier carries parity bits
package full_status_pkg;
  localparam logic [7:0] ID_DIAG      = 8'h3C; // long preparing frame
  localparam logic [7:0] ID_INDIRECT  = 8'h7D; // both responses
  localparam logic [7:0] APP_CMD      = 8'h80;
  localparam logic [6:0] CMD_FULL     = 7'h01;
  localparam logic [7:0] FILL_BYTE    = 8'hFF;
  localparam logic       TOP_ONE      = 1'b1;
  localparam logic [3:0] SHORT_LEN    = 4'h2;  // data bytes, short form
  localparam logic [3:0] LONG_LEN     = 4'h8;  // data bytes, long form
  localparam logic [3:0] RESP_LEN     = 4'h8;  // data bytes per response
  // host register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TARGET   = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_R1_LO    = 8'h14;
  localparam logic [7:0] OFS_R1_HI    = 8'h18;
  localparam logic [7:0] OFS_R2_LO    = 8'h1C;
  localparam logic [7:0] OFS_R2_HI    = 8'h20;
  localparam int         CTRL_START   = 0;
  localparam int         CTRL_LONG    = 1;
  localparam int         CTRL_SECOND  = 2;
  localparam int         EV_DONE      = 0;
  localparam int         EV_CKS_ERR   = 1;
  localparam int         EV_NO_RESP   = 2;
  localparam int         EV_W         = 3;

  // protected identifier: parity over six identifier bits
  function automatic logic [7:0] lin_pid(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // classic sum with end-around carry; transmit its inverse
  function automatic logic [7:0] cks_add(input logic [7:0] s,
                                         input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction
endpackage

// ===== lin_frame_if.sv
// byte-level frame carrier between bus master and status responder
// assumes both ends on the same clock; the bench provides clk
`timescale 1ns/1ps
interface lin_frame_if;
  logic       hdr_valid; // one-cycle header pulse
  logic [7:0] hdr_id;    // protected identifier
  logic       m_valid;   // master data byte strobe
  logic [7:0] m_data;
  logic       s_valid;   // responder data byte strobe
  logic [7:0] s_data;
  modport master (output hdr_valid, hdr_id, m_valid, m_data,
                  input  s_valid, s_data);
  modport slave  (input  hdr_valid, hdr_id, m_valid, m_data,
                  output s_valid, s_data);
endinterface

// ===== full_status_responder.sv
// device end: decodes full status preparing frames and answers polls
// assumes master never overlaps headers and data bytes in one cycle
`timescale 1ns/1ps
module full_status_responder
  import full_status_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link
  lin_frame_if.slave       link,
  // node identity
  input  wire logic [6:0]  node_address,
  input  wire logic [4:0]  direct_id,
  // motion parameters
  input  wire logic [3:0]  run_current,
  input  wire logic [3:0]  hold_current,
  input  wire logic [3:0]  max_velocity,
  input  wire logic [3:0]  min_velocity,
  input  wire logic        accel_shape,
  input  wire logic [1:0]  step_resolution,
  input  wire logic        shaft,
  input  wire logic [3:0]  acceleration,
  // latched faults and state
  input  wire logic        supply_reset_flag,
  input  wire logic        step_loss_flag,
  input  wire logic        electrical_defect_flag,
  input  wire logic        undervoltage_flag,
  input  wire logic        thermal_shutdown_flag,
  input  wire logic        thermal_warning_flag,
  input  wire logic [1:0]  temp_info,
  input  wire logic [2:0]  motion_state,
  input  wire logic        external_switch,
  input  wire logic        overcurrent_coil_x,
  input  wire logic        overcurrent_coil_y,
  input  wire logic        charge_pump_fail,
  input  wire logic        timeout_error,
  input  wire logic        data_error,
  input  wire logic        header_error,
  input  wire logic        bit_error,
  // positions
  input  wire logic [15:0] actual_position,
  input  wire logic [15:0] target_position,
  input  wire logic [10:0] secure_position,
  // status to the core
  output      logic        flag_clear,
  output      logic        query_pending
);
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} state_t;
  typedef enum logic [1:0] {STG_NONE, STG_FIRST, STG_SECOND} stage_t;

  state_t     state_q;
  stage_t     stage_q;
  logic       long_q;
  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [7:0] rx_q [0:7];
  logic [7:0] tx_q [0:7];
  logic       s_valid_q;
  logic [7:0] s_data_q;
  logic       clear_q;
  logic [3:0] rx_len;
  logic       hdr_short;
  logic       hdr_long;
  logic       hdr_poll;
  logic       body_ok;
  logic       rx_end;
  logic       tx_end;

  // header classification
  assign hdr_short = link.hdr_valid &&
                     (link.hdr_id == lin_pid({1'b0, direct_id}));
  assign hdr_long  = link.hdr_valid && (link.hdr_id == ID_DIAG);
  assign hdr_poll  = link.hdr_valid && (link.hdr_id == ID_INDIRECT) &&
                     (stage_q != STG_NONE);
  assign rx_len    = long_q ? LONG_LEN : SHORT_LEN;
  assign rx_end    = (state_q == ST_RX) && link.m_valid &&
                     (cnt_q == rx_len);
  assign tx_end    = (state_q == ST_TX) && (cnt_q == RESP_LEN);

  // frame body check for the two preparing forms
  always_comb begin
    body_ok = 1'b1;
    if (long_q) begin
      body_ok = (rx_q[0] == APP_CMD) &&
                (rx_q[1] == {TOP_ONE, CMD_FULL}) &&
                (rx_q[2] == {TOP_ONE, node_address});
      for (int i = 3; i < 8; i++) begin
        if (rx_q[i] != FILL_BYTE) begin
          body_ok = 1'b0;
        end
      end
    end else begin
      body_ok = (rx_q[0] == {TOP_ONE, CMD_FULL}) &&
                (rx_q[1] == {TOP_ONE, node_address});
    end
  end

  // frame sequencer; a new header always aborts the frame in progress
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      long_q  <= 1'b0;
      cnt_q   <= 4'h0;
      sum_q   <= 8'h00;
    end else if (hdr_short || hdr_long) begin
      state_q <= ST_RX;
      long_q  <= hdr_long;
      cnt_q   <= 4'h0;
      sum_q   <= 8'h00;
    end else if (hdr_poll) begin
      state_q <= ST_TX;
      cnt_q   <= 4'h0;
      sum_q   <= 8'h00;
    end else if (link.hdr_valid || rx_end || tx_end) begin
      state_q <= ST_IDLE;
    end else if (state_q == ST_RX && link.m_valid) begin
      cnt_q <= cnt_q + 4'h1;
      sum_q <= cks_add(sum_q, link.m_data);
    end else if (state_q == ST_TX) begin
      cnt_q <= cnt_q + 4'h1;
      sum_q <= cks_add(sum_q, tx_q[cnt_q[2:0]]);
    end
  end

  // receive byte store
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        rx_q[i] <= 8'h00;
      end
    end else if (state_q == ST_RX && link.m_valid && cnt_q < rx_len) begin
      rx_q[cnt_q[2:0]] <= link.m_data;
    end
  end

  // query progress; mismatching frames leave it untouched
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_q <= STG_NONE;
    end else if (rx_end && body_ok && (~sum_q == link.m_data)) begin
      stage_q <= STG_FIRST;
    end else if (tx_end) begin
      // ending after the first answer is legal; second stays armed
      stage_q <= (stage_q == STG_FIRST) ? STG_SECOND : STG_NONE;
    end
  end

  // response image, frozen at the poll header so bytes are coherent
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        tx_q[i] <= 8'h00;
      end
    end else if (hdr_poll && stage_q == STG_FIRST) begin
      tx_q[0] <= {TOP_ONE, node_address};
      tx_q[1] <= {run_current, hold_current};
      tx_q[2] <= {max_velocity, min_velocity};
      tx_q[3] <= {accel_shape, step_resolution, shaft, acceleration};
      tx_q[4] <= {supply_reset_flag, step_loss_flag,
                  electrical_defect_flag, undervoltage_flag,
                  thermal_shutdown_flag, thermal_warning_flag,
                  temp_info};
      tx_q[5] <= {motion_state, external_switch, overcurrent_coil_x,
                  overcurrent_coil_y, TOP_ONE, charge_pump_fail};
      tx_q[6] <= {4'hF, timeout_error, data_error, header_error,
                  bit_error};
      tx_q[7] <= FILL_BYTE;
    end else if (hdr_poll) begin
      tx_q[0] <= {TOP_ONE, node_address};
      tx_q[1] <= actual_position[15:8];
      tx_q[2] <= actual_position[7:0];
      tx_q[3] <= target_position[15:8];
      tx_q[4] <= target_position[7:0];
      tx_q[5] <= secure_position[7:0];
      tx_q[6] <= {5'h1F, secure_position[10:8]};
      tx_q[7] <= FILL_BYTE;
    end
  end

  // registered byte output; checksum is the last byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_valid_q <= 1'b0;
      s_data_q  <= 8'h00;
    end else if (state_q == ST_TX && !link.hdr_valid) begin
      s_valid_q <= 1'b1;
      s_data_q  <= (cnt_q == RESP_LEN) ? ~sum_q
                                       : tx_q[cnt_q[2:0]];
    end else begin
      s_valid_q <= 1'b0;
    end
  end

  // fault clear once the flag response has gone out
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= tx_end && (stage_q == STG_FIRST);
    end
  end

  assign link.s_valid  = s_valid_q;
  assign link.s_data   = s_data_q;
  assign flag_clear    = clear_q;
  assign query_pending = (stage_q != STG_NONE);
endmodule

// ===== full_status_asserts.sv
// checker for the frame carrier between master and responder ends
// assumes one clock; instantiated beside the carrier by the bench
`timescale 1ns/1ps
module full_status_asserts
  import full_status_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // carrier
  input wire logic       hdr_valid,
  input wire logic [7:0] hdr_id,
  input wire logic       m_valid,
  input wire logic [7:0] m_data,
  input wire logic       s_valid,
  input wire logic [7:0] s_data,
  // responder status
  input wire logic       flag_clear,
  input wire logic       query_pending
);
  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [8:0] add_t;
  logic       poll_armed;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // own running sum, kept apart from the design's helper on purpose
  assign add_t = {1'b0, sum_q} + {1'b0, s_data};
  always_ff @(posedge clk) begin
    if (!reset_n || hdr_valid) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
    end else if (s_valid) begin
      cnt_q <= cnt_q + 4'h1;
      sum_q <= add_t[7:0] + {7'h00, add_t[8]};
    end
  end
  // poll that finds a response armed
  assign poll_armed = hdr_valid && hdr_id == ID_INDIRECT && query_pending;

  a_resp_nine_bytes: assert property (
    poll_armed |-> ##2 s_valid [*8] ##1 s_valid)
    else $error("response not nine bytes after poll");
  a_silent_poll: assert property (
    hdr_valid && hdr_id == ID_INDIRECT && !query_pending |-> ##1 !s_valid [*8])
    else $error("unarmed poll answered");
  a_addr_top_bit: assert property (
    poll_armed |-> ##2 s_data[7])
    else $error("address byte top bit low");
  a_byte7_ones: assert property (
    poll_armed |-> ##8 s_data[7:4] == 4'hF)
    else $error("seventh byte upper ones missing");
  a_last_fill: assert property (
    poll_armed |-> ##9 s_data == FILL_BYTE)
    else $error("eighth byte not fill");
  a_sum_byte: assert property (
    s_valid && cnt_q == 4'h8 |-> s_data == ~sum_q)
    else $error("response checksum wrong");
  a_clear_single: assert property (
    flag_clear |=> !flag_clear)
    else $error("clear pulse longer than one cycle");
  // clear is launched on the same edge as the checksum byte
  a_clear_after_resp: assert property (
    $rose(flag_clear) |-> s_valid && cnt_q == 4'h8)
    else $error("clear not with checksum byte");
  a_short_parity: assert property (
    hdr_valid && !hdr_id[5] |-> hdr_id[6] == ^{hdr_id[4], hdr_id[2:0]}
      && hdr_id[7] == ~^{hdr_id[5:3], hdr_id[1]})
    else $error("short identifier parity wrong");
  a_short_cmd: assert property (
    hdr_valid && !hdr_id[5] |-> ##[1:4] (m_valid && m_data == 8'h81))
    else $error("short frame command byte wrong");
  a_long_app: assert property (
    hdr_valid && hdr_id == ID_DIAG |-> ##[1:4] (m_valid && m_data == APP_CMD))
    else $error("long frame application byte wrong");

  // main scenarios reached
  c_poll: cover property (poll_armed);
  c_clear: cover property (flag_clear);
  c_long: cover property (hdr_valid && hdr_id == ID_DIAG);
endmodule

// ===== tb_lin_full_status_responder.sv
// self-checking bench: APB-driven master end facing the responder end
// assumes a 40 MHz clock; both ends joined through one frame carrier
`timescale 1ns/1ps
module tb_lin_full_status_responder;
  import full_status_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        flag_clear, query_pending;
  logic [6:0]  node_address;
  logic [4:0]  direct_id;
  logic [3:0]  run_current, hold_current, max_velocity, min_velocity;
  logic [3:0]  acceleration;
  logic [1:0]  step_resolution, temp_info;
  logic [2:0]  motion_state;
  logic        accel_shape, shaft, supply_reset_flag, step_loss_flag;
  logic        electrical_defect_flag, undervoltage_flag, bit_error;
  logic        thermal_shutdown_flag, thermal_warning_flag, data_error;
  logic        external_switch, overcurrent_coil_x, overcurrent_coil_y;
  logic        charge_pump_fail, timeout_error, header_error;
  logic [15:0] actual_position, target_position;
  logic [10:0] secure_position;
  logic [85:0] pattern;
  int          failures, tests_run, clears;

  lin_frame_if lf ();
  full_status_master #(.RESP_WAIT(16)) full_status_master_i (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .link(lf.master));
  full_status_responder full_status_responder_i (
    .clk, .reset_n, .link(lf.slave), .node_address, .direct_id,
    .run_current, .hold_current, .max_velocity, .min_velocity,
    .accel_shape, .step_resolution, .shaft, .acceleration,
    .supply_reset_flag, .step_loss_flag, .electrical_defect_flag,
    .undervoltage_flag, .thermal_shutdown_flag, .thermal_warning_flag,
    .temp_info, .motion_state, .external_switch, .overcurrent_coil_x,
    .overcurrent_coil_y, .charge_pump_fail, .timeout_error, .data_error,
    .header_error, .bit_error, .actual_position, .target_position,
    .secure_position, .flag_clear, .query_pending);
  full_status_asserts full_status_asserts_i (
    .clk, .reset_n, .hdr_valid(lf.hdr_valid), .hdr_id(lf.hdr_id),
    .m_valid(lf.m_valid), .m_data(lf.m_data), .s_valid(lf.s_valid),
    .s_data(lf.s_data), .flag_clear, .query_pending);

  // 25 ns period
  always #12.5 clk = ~clk;

  // count fault-clear pulses from the responder
  always @(posedge clk) begin
    if (flag_clear === 1'b1) clears++;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one APB transfer; an idle edge first so no signal is set twice
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(what, exp, rd);
  endtask

  // poll event status until something is reported, bounded
  task automatic wait_event();
    int n;
    n = 0;
    do begin
      apb(OFS_INT_STAT, 1'b0, 32'h0);
      n++;
    end while (rd === 32'h0 && n < 100);
    check("event seen", 32'h1, {31'h0, rd !== 32'h0});
  endtask

  // spread one pattern over every status input
  task automatic load(input logic [85:0] v);
    {run_current, hold_current, max_velocity, min_velocity, acceleration,
     step_resolution, temp_info, motion_state, accel_shape, shaft,
     supply_reset_flag, step_loss_flag, electrical_defect_flag,
     undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag,
     external_switch, overcurrent_coil_x, overcurrent_coil_y,
     charge_pump_fail, timeout_error, data_error, header_error, bit_error,
     actual_position, target_position, secure_position} <= v;
  endtask

  function automatic logic [31:0] r1_hi();
    return {1'b1, node_address, run_current, hold_current, max_velocity,
            min_velocity, accel_shape, step_resolution, shaft, acceleration};
  endfunction
  function automatic logic [31:0] r1_lo();
    return {supply_reset_flag, step_loss_flag, electrical_defect_flag,
            undervoltage_flag, thermal_shutdown_flag, thermal_warning_flag,
            temp_info, motion_state, external_switch, overcurrent_coil_x,
            overcurrent_coil_y, 1'b1, charge_pump_fail, 4'hF, timeout_error,
            data_error, header_error, bit_error, 8'hFF};
  endfunction
  function automatic logic [31:0] r2_hi();
    return {1'b1, node_address, actual_position, target_position[15:8]};
  endfunction
  function automatic logic [31:0] r2_lo();
    return {target_position[7:0], secure_position[7:0], 5'h1F,
            secure_position[10:8], 8'hFF};
  endfunction

  // main sequence
  initial begin
    failures = 0;
    tests_run = 0;
    clears = 0;
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    node_address = 7'h2A;
    direct_id = 5'h15;
    pattern = 86'h3A5_C396_E15A_3C0F_F069_5A1;
    load(pattern);
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("int_stat reset", OFS_INT_STAT, 32'h0);
    check("pending reset", 32'h0, {31'h0, query_pending});
    rdchk("unmapped read", 8'h40, 32'h0);
    check("slverr low", 32'h0, {31'h0, pslverr});
    apb(OFS_TARGET, 1'b1, 32'h0000_152A);
    apb(OFS_INT_MASK, 1'b1, 32'h0000_0007);
    // short form, both responses fetched
    apb(OFS_CTRL, 1'b1, 32'h5);
    wait_event();
    check("irq done", 32'h1, {31'h0, irq});
    rdchk("int_stat done", OFS_INT_STAT, 32'h1);
    rdchk("resp1 hi", OFS_R1_HI, r1_hi());
    rdchk("resp1 lo", OFS_R1_LO, r1_lo());
    rdchk("resp2 hi", OFS_R2_HI, r2_hi());
    rdchk("resp2 lo", OFS_R2_LO, r2_lo());
    check("clears", 32'h1, clears);
    apb(OFS_INT_STAT, 1'b1, 32'h1);
    rdchk("int_stat w1c", OFS_INT_STAT, 32'h0);
    check("irq cleared", 32'h0, {31'h0, irq});
    // foreign address: frame ignored, poll unanswered, no clear
    node_address <= 7'h11;
    apb(OFS_CTRL, 1'b1, 32'h1);
    rdchk("status busy", OFS_STATUS, 32'h1);
    wait_event();
    rdchk("no response", OFS_INT_STAT, 32'h4);
    check("no clear", 32'h1, clears);
    apb(OFS_INT_STAT, 1'b1, 32'h4);
    node_address <= 7'h2A;
    // long form, first response only, done masked
    load(~pattern);
    apb(OFS_INT_MASK, 1'b1, 32'h0);
    apb(OFS_CTRL, 1'b1, 32'h3);
    wait_event();
    check("irq masked", 32'h0, {31'h0, irq});
    rdchk("ctrl readback", OFS_CTRL, 32'h2);
    rdchk("status idle", OFS_STATUS, 32'h0);
    rdchk("long resp1 hi", OFS_R1_HI, r1_hi());
    rdchk("long resp1 lo", OFS_R1_LO, r1_lo());
    check("long clears", 32'h2, clears);
    check("second armed", 32'h1, {31'h0, query_pending});
    apb(OFS_INT_MASK, 1'b1, 32'h1);
    @(posedge clk);
    check("irq unmasked", 32'h1, {31'h0, irq});
    apb(OFS_INT_STAT, 1'b1, 32'h1);
    @(posedge clk);
    check("irq final", 32'h0, {31'h0, irq});
    end_sim();
  end

  // hang guard: about 20000 cycles
  initial begin
    #500000;
    failures++;
    end_sim();
  end
endmodule
